/* verilog/hpf_pkg.sv */
package hpf_pkg;
  localparam int DATA_W = 32;
  localparam int QUEUES = 3;
  typedef logic [7:0] hpf_addr_t;
  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam hpf_addr_t OFS_DEST_LO = 8'h68;
  localparam hpf_addr_t OFS_HDR_INFO = 8'h6C;
  localparam hpf_addr_t OFS_HEAD = 8'h70;
  localparam hpf_addr_t OFS_BODY = 8'h74;
  localparam hpf_addr_t OFS_TAIL = 8'h78;
  localparam hpf_addr_t OFS_RX [0:2] = '{8'h80, 8'h84, 8'h88};
  localparam hpf_addr_t OFS_ROM = 8'h8C;
  // ----------------------------------------
  // Fields and reset values
  // ----------------------------------------
  localparam int TCODE_LSB = 0;
  localparam int SPD_LSB = 4;
  localparam int LABEL_LSB = 6;
  localparam int RETRY_LSB = 12;
  localparam int SPLIT_LSB = 16;
  localparam int AR_LSB = 6;
  localparam int AR_W = 10;
  localparam int ROM_LSB = 21;
  localparam int ROM_W = 11;
  localparam logic [AR_W-1:0] AR_LIMIT = 10'h228;
  localparam logic [ROM_W-1:0] ROM_LIMIT = 11'h400;
  localparam logic [31:0] RST_ZERO = 32'h00000000;
  localparam logic [15:0] SPLIT_MAX = 16'hFFFF;
  // Queue choice from the head quadlet
  localparam int HDR_TCODE_LSB = 4;
  localparam int HDR_LABEL_LSB = 10;
  localparam logic [3:0] TCODE_PHY = 4'hE;
  localparam logic [1:0] LBL_MGMT = 2'h2;
  localparam logic [1:0] LBL_CMD = 2'h3;
  typedef enum logic [1:0] {HPF_Q_ASYNC, HPF_Q_MGMT, HPF_Q_CMD} hpf_queue_t;
  // Timer selector codes
  localparam logic [3:0] TSEL_DATA_TX = 4'h0;
  localparam logic [3:0] TSEL_DATA_RX = 4'h1;
  localparam logic [3:0] TSEL_MGMT = 4'h2;
  localparam logic [3:0] TSEL_CMD = 4'h4;
  localparam logic [3:0] TSEL_AUTO = 4'h6;
  // Bus
  localparam logic [3:0] STRB_FULL = 4'hF;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam int FIFO_DEPTH = 4;
  localparam int FIFO_W = 34;
endpackage : hpf_pkg

/* verilog/hpf_stream_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface hpf_stream_if #(parameter int W = 34) ();
  logic valid;
  logic ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : hpf_stream_if
`default_nettype wire

/* verilog/hpf_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module hpf_fifo #(
  parameter int W = 34,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  hpf_stream_if.snk in_s,
  hpf_stream_if.src out_s
);
  localparam int PW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH + 1);
  localparam logic [PW-1:0] PTR_LAST = PW'(DEPTH - 1);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [PW-1:0] wr_ptr_reg;
  logic [PW-1:0] rd_ptr_reg;
  logic [CW-1:0] count_reg;
  logic push;
  logic pop;
  assign in_s.ready = (count_reg != CNT_FULL);
  assign out_s.valid = (count_reg != '0);
  assign out_s.data = mem[rd_ptr_reg];
  assign push = in_s.valid && in_s.ready;
  assign pop = out_s.valid && out_s.ready;
  always_ff @(posedge aclk)
  begin
    if (push)
      mem[wr_ptr_reg] <= in_s.data;
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end
    else
    begin
      if (push)
        wr_ptr_reg <= (wr_ptr_reg == PTR_LAST) ? '0 : wr_ptr_reg + 1'b1;
      if (pop)
        rd_ptr_reg <= (rd_ptr_reg == PTR_LAST) ? '0 : rd_ptr_reg + 1'b1;
      if (push && !pop)
        count_reg <= count_reg + 1'b1;
      else if (pop && !push)
        count_reg <= count_reg - 1'b1;
    end
  end
endmodule : hpf_fifo
`default_nettype wire

/* verilog/hpf_split_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module hpf_split_timer
  import hpf_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic clear,
  input wire logic cycle_start,
  input wire logic waiting,
  output logic [15:0] count
);
  logic [15:0] count_reg;
  assign count = count_reg;
  // Saturates so a lost response never wraps back to a short wait
  always_ff @(posedge aclk)
  begin
    if (!aresetn || clear)
      count_reg <= '0;
    else if (cycle_start && waiting && count_reg != SPLIT_MAX)
      count_reg <= count_reg + 16'h0001;
  end
  property p_split_step;
    @(posedge aclk) disable iff (!aresetn)
    (cycle_start && waiting && !clear && count_reg != SPLIT_MAX)
      |=> count_reg == $past(count_reg) + 16'h0001;
  endproperty
  a_split_step: assert property (p_split_step)
    else $error("split wait timer did not advance on cycle start");
endmodule : hpf_split_timer
`default_nettype wire

/* verilog/hpf_regs.sv */
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hpf_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic bus_reset,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [3:0] timer_selector,
  input wire logic [31:0] timer_dest_offset_low,
  input wire logic [3:0] timer_tcode,
  input wire logic [1:0] timer_speed,
  input wire logic [5:0] timer_label,
  input wire logic [3:0] timer_retry_limit,
  input wire logic timer_start,
  input wire logic timer_waiting,
  input wire logic cycle_start,
  output logic [31:0] tx_data,
  output logic [2:0] tx_valid,
  input wire logic [2:0] tx_ready,
  input wire logic [2:0][31:0] rx_data,
  input wire logic [2:0] rx_empty,
  output logic [2:0] rx_pop,
  output logic [9:0] auto_reply_rom_bytes,
  output logic [10:0] rom_total_bytes
);
  import hpf_pkg::*;
  // ----------------------------------------
  // Write channel
  // ----------------------------------------
  logic awready_reg;
  logic wready_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic [7:0] awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0] wstrb_reg;
  logic wr_go;
  logic wr_push;
  logic wr_err;
  logic is_head;
  logic is_body_tail;
  logic strb_ok;
  logic range_ok;
  logic head_seen_reg;
  hpf_queue_t queue_reg;
  hpf_queue_t push_queue;
  logic [AR_W-1:0] auto_reply_rom_bytes_reg;
  logic [ROM_W-1:0] rom_total_bytes_reg;
  logic [AR_W-1:0] new_ar;
  logic [ROM_W-1:0] new_rom;
  hpf_stream_if #(.W(FIFO_W)) fifo_in ();
  hpf_stream_if #(.W(FIFO_W)) fifo_out ();

  function automatic hpf_queue_t pick_queue(input logic [31:0] q);
    logic [5:0] lbl;
    logic [3:0] tc;
    lbl = q[HDR_LABEL_LSB +: 6];
    tc = q[HDR_TCODE_LSB +: 4];
    if (tc == TCODE_PHY)
      pick_queue = HPF_Q_ASYNC;
    else if (lbl[5:4] == LBL_CMD)
      pick_queue = HPF_Q_CMD;
    else if (lbl[5:4] == LBL_MGMT)
      pick_queue = HPF_Q_MGMT;
    else
      pick_queue = HPF_Q_ASYNC;
  endfunction : pick_queue

  assign s_axi_awready = awready_reg;
  assign s_axi_wready = wready_reg;
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;
  assign is_head = (awaddr_reg == OFS_HEAD);
  assign is_body_tail = (awaddr_reg == OFS_BODY) || (awaddr_reg == OFS_TAIL);
  assign strb_ok = (wstrb_reg == STRB_FULL);
  assign new_ar = wdata_reg[AR_LSB +: AR_W];
  assign new_rom = wdata_reg[ROM_LSB +: ROM_W];
  assign range_ok = (new_ar < AR_LIMIT) && (new_rom < ROM_LIMIT);
  // Full FIFO stalls the response of head, body and tail writes, which is the back-pressure to software
  assign wr_go = !awready_reg && !wready_reg && !bvalid_reg
                 && (!(is_head || is_body_tail) || fifo_in.ready);
  // Orphan body and tail quadlets never reach a queue
  assign wr_push = wr_go && strb_ok && (is_head || (is_body_tail && head_seen_reg));
  assign push_queue = is_head ? pick_queue(wdata_reg) : queue_reg;
  assign fifo_in.valid = wr_push;
  assign fifo_in.data = {push_queue, wdata_reg};

  always_comb
  begin
    wr_err = 1'b1;
    if (!strb_ok)
      wr_err = 1'b1;
    else if (is_head || is_body_tail)
      wr_err = 1'b0;
    else if (awaddr_reg == OFS_ROM)
      wr_err = !range_ok;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      awready_reg <= 1'b1;
      wready_reg <= 1'b1;
      awaddr_reg <= '0;
      wdata_reg <= RST_ZERO;
      wstrb_reg <= '0;
    end
    else
    begin
      if (s_axi_awvalid && awready_reg)
      begin
        awaddr_reg <= s_axi_awaddr;
        awready_reg <= 1'b0;
      end
      else if (wr_go)
        awready_reg <= 1'b1;
      if (s_axi_wvalid && wready_reg)
      begin
        wdata_reg <= s_axi_wdata;
        wstrb_reg <= s_axi_wstrb;
        wready_reg <= 1'b0;
      end
      else if (wr_go)
        wready_reg <= 1'b1;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end
    else if (wr_go)
    begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_err ? RESP_SLVERR : RESP_OKAY;
    end
    else if (s_axi_bready)
      bvalid_reg <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn || bus_reset)
    begin
      head_seen_reg <= 1'b0;
      queue_reg <= HPF_Q_ASYNC;
    end
    else if (wr_push && is_head)
    begin
      head_seen_reg <= 1'b1;
      queue_reg <= pick_queue(wdata_reg);
    end
  end

  // ROM sizes survive bus reset; only the system reset clears them
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      auto_reply_rom_bytes_reg <= '0;
      rom_total_bytes_reg <= '0;
    end
    else if (wr_go && awaddr_reg == OFS_ROM && strb_ok && range_ok)
    begin
      auto_reply_rom_bytes_reg <= new_ar;
      rom_total_bytes_reg <= new_rom;
    end
  end
  assign auto_reply_rom_bytes = auto_reply_rom_bytes_reg;
  assign rom_total_bytes = rom_total_bytes_reg;

  // ----------------------------------------
  // Transmit queue buffer
  // ----------------------------------------
  // Flushed on bus reset: a half-written packet is worthless after it
  hpf_fifo #(.W(FIFO_W), .DEPTH(FIFO_DEPTH)) u_tx_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(bus_reset),
    .in_s(fifo_in),
    .out_s(fifo_out)
  );
  assign tx_data = fifo_out.data[31:0];
  assign fifo_out.ready = |(tx_valid & tx_ready);
  for (genvar q = 0; q < QUEUES; q++)
  begin : g_txq
    assign tx_valid[q] = fifo_out.valid && (fifo_out.data[33:32] == 2'(q));
  end

  // ----------------------------------------
  // Timer status
  // ----------------------------------------
  logic [31:0] dest_lo_reg;
  logic [15:0] hdr_reg;
  logic [15:0] split_count;
  logic [3:0] sel_prev_reg;
  logic sel_legal;
  assign sel_legal = (timer_selector == TSEL_DATA_TX) || (timer_selector == TSEL_DATA_RX)
                     || (timer_selector == TSEL_MGMT) || (timer_selector == TSEL_CMD)
                     || (timer_selector == TSEL_AUTO);
  always_ff @(posedge aclk)
  begin
    if (!aresetn || bus_reset || !sel_legal)
    begin
      dest_lo_reg <= RST_ZERO;
      hdr_reg <= '0;
    end
    else
    begin
      dest_lo_reg <= timer_dest_offset_low;
      hdr_reg[TCODE_LSB +: 4] <= timer_tcode;
      hdr_reg[SPD_LSB +: 2] <= timer_speed;
      hdr_reg[LABEL_LSB +: 6] <= timer_label;
      hdr_reg[RETRY_LSB +: 4] <= timer_retry_limit;
    end
  end
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sel_prev_reg <= TSEL_DATA_TX;
    else
      sel_prev_reg <= timer_selector;
  end
  // Restart on a new selection so the count always belongs to the shown timer
  hpf_split_timer u_split (
    .aclk(aclk),
    .aresetn(aresetn),
    .clear(bus_reset || timer_start || timer_selector != sel_prev_reg || !sel_legal),
    .cycle_start(cycle_start),
    .waiting(timer_waiting),
    .count(split_count)
  );

  // ----------------------------------------
  // Read channel and receive pops
  // ----------------------------------------
  logic arready_reg;
  logic rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0] rresp_reg;
  logic [2:0] rx_pop_reg;
  logic [31:0] last_reg [3];
  logic [31:0] rx_val [3];
  logic [2:0] rx_hit;
  logic rd_go;
  assign rd_go = s_axi_arvalid && arready_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata = rdata_reg;
  assign s_axi_rresp = rresp_reg;
  assign rx_pop = rx_pop_reg;

  for (genvar i = 0; i < QUEUES; i++)
  begin : g_rx
    assign rx_hit[i] = rd_go && (s_axi_araddr == OFS_RX[i]);
    // Empty FIFO: hand back the last quadlet again, pop nothing
    assign rx_val[i] = rx_empty[i] ? last_reg[i] : rx_data[i];
    always_ff @(posedge aclk)
    begin
      if (!aresetn || bus_reset)
      begin
        last_reg[i] <= RST_ZERO;
        rx_pop_reg[i] <= 1'b0;
      end
      else
      begin
        rx_pop_reg[i] <= rx_hit[i] && !rx_empty[i];
        if (rx_hit[i] && !rx_empty[i])
          last_reg[i] <= rx_data[i];
      end
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      arready_reg <= 1'b1;
      rvalid_reg <= 1'b0;
      rdata_reg <= RST_ZERO;
      rresp_reg <= RESP_OKAY;
    end
    else if (rd_go)
    begin
      arready_reg <= 1'b0;
      rvalid_reg <= 1'b1;
      rresp_reg <= RESP_OKAY;
      unique case (s_axi_araddr)
        OFS_DEST_LO: rdata_reg <= dest_lo_reg;
        OFS_HDR_INFO: rdata_reg <= {split_count, hdr_reg};
        OFS_HEAD, OFS_BODY, OFS_TAIL: rdata_reg <= RST_ZERO;
        OFS_RX[0]: rdata_reg <= rx_val[0];
        OFS_RX[1]: rdata_reg <= rx_val[1];
        OFS_RX[2]: rdata_reg <= rx_val[2];
        OFS_ROM: rdata_reg <= {rom_total_bytes_reg, 5'h00, auto_reply_rom_bytes_reg, 6'h00};
        default:
        begin
          rdata_reg <= RST_ZERO;
          rresp_reg <= RESP_SLVERR;
        end
      endcase
    end
    else if (rvalid_reg && s_axi_rready)
    begin
      rvalid_reg <= 1'b0;
      arready_reg <= 1'b1;
    end
  end

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_dest_read;
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == OFS_DEST_LO) |=> rvalid_reg && rdata_reg == $past(dest_lo_reg);
  endproperty
  a_dest_read: assert property (p_dest_read)
    else $error("offset low read returned wrong value");
  property p_tcode_read;
    @(posedge aclk) disable iff (!aresetn)
    (rd_go && s_axi_araddr == OFS_HDR_INFO) |=> rdata_reg[3:0] == $past(hdr_reg[3:0]);
  endproperty
  a_tcode_read: assert property (p_tcode_read)
    else $error("transaction code field wrong");
  property p_head_arms;
    @(posedge aclk) disable iff (!aresetn)
    (wr_push && is_head && !bus_reset) |=> head_seen_reg && queue_reg == $past(push_queue);
  endproperty
  a_head_arms: assert property (p_head_arms)
    else $error("head write did not fix the queue");
  property p_orphan_drop;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && is_body_tail && !head_seen_reg) |-> !fifo_in.valid;
  endproperty
  a_orphan_drop: assert property (p_orphan_drop)
    else $error("orphan body or tail quadlet was pushed");
  property p_async_empty;
    @(posedge aclk) disable iff (!aresetn)
    (rx_hit[0] && rx_empty[0] && !bus_reset)
      |=> rdata_reg == $past(last_reg[0]) && !rx_pop_reg[0];
  endproperty
  a_async_empty: assert property (p_async_empty)
    else $error("empty async read did not repeat last value");
  property p_bus_reset_clear;
    @(posedge aclk) disable iff (!aresetn)
    bus_reset |=> last_reg[1] == RST_ZERO && last_reg[2] == RST_ZERO && rx_pop_reg == 3'h0;
  endproperty
  a_bus_reset_clear: assert property (p_bus_reset_clear)
    else $error("receive read registers not cleared by bus reset");
  property p_rom_keeps;
    @(posedge aclk) disable iff (!aresetn)
    (bus_reset && !wr_go) |=> $stable(rom_total_bytes_reg) && $stable(auto_reply_rom_bytes_reg);
  endproperty
  a_rom_keeps: assert property (p_rom_keeps)
    else $error("bus reset disturbed ROM control");
  property p_rom_range;
    @(posedge aclk) disable iff (!aresetn)
    (wr_go && awaddr_reg == OFS_ROM && new_rom >= ROM_LIMIT)
      |=> $stable(rom_total_bytes_reg) && bresp_reg == RESP_SLVERR;
  endproperty
  a_rom_range: assert property (p_rom_range)
    else $error("out of range ROM size accepted");
endmodule : hpf_regs
`default_nettype wire

/* dv/hpf_far_end.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Far side: tx queue sink and rx FIFOs
// ----------------------------------------
module hpf_far_end (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic stall,
  input wire logic [2:0] rx_pop,
  output logic [2:0] tx_ready,
  output logic [2:0][31:0] rx_data,
  output logic [2:0] rx_empty
);
  // Two words per rx FIFO; not cleared by a bus reset, as the real FIFOs
  logic [1:0] cnt [3];
  always_ff @(posedge aclk)
  begin
    for (int i = 0; i < 3; i++)
    begin
      if (!aresetn)
        cnt[i] <= 2'h0;
      else if (rx_pop[i] && cnt[i] < 2'h2)
        cnt[i] <= cnt[i] + 2'h1;
    end
  end
  // Empty FIFO shows inverted last word, so a held value cannot pass by luck
  always_comb
  begin
    for (int i = 0; i < 3; i++)
    begin
      rx_empty[i] = (cnt[i] == 2'h2);
      rx_data[i] = 32'hA0000000 | (i << 16) | 32'(cnt[i]);
      if (rx_empty[i])
        rx_data[i] = ~(32'hA0000001 | (i << 16));
    end
  end
  assign tx_ready = {3{~stall}};
endmodule : hpf_far_end
`default_nettype wire

/* dv/test_hpf_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module test_hpf_regs;
  import hpf_pkg::*;
  logic aclk = 1'b0, aresetn = 1'b0, bus_reset = 1'b0, stall = 1'b0, v;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, timer_dest_offset_low = 32'h0;
  logic [3:0] s_axi_wstrb = 4'hF, timer_selector = 4'h0, timer_tcode = 4'h0;
  logic [3:0] timer_retry_limit = 4'h0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [1:0] timer_speed = 2'h0;
  logic [5:0] timer_label = 6'h0;
  logic timer_start = 1'b0, timer_waiting = 1'b0, cycle_start = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, tx_data, seed = 32'h6F17;
  logic [2:0] tx_valid, tx_ready, rx_empty, rx_pop;
  logic [2:0][31:0] rx_data;
  logic [9:0] auto_reply_rom_bytes;
  logic [10:0] rom_total_bytes;
  logic [3:0] sels [7] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h6, 4'h5, 4'h7};
  logic [33:0] rd_q [$], tx_q [$], e, m;
  int num_errors = 0, compares = 0;

  always #5 aclk = ~aclk;

  hpf_regs uut (.aclk, .aresetn, .bus_reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_selector, .timer_dest_offset_low,
    .timer_tcode, .timer_speed, .timer_label, .timer_retry_limit, .timer_start,
    .timer_waiting, .cycle_start, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_empty,
    .rx_pop, .auto_reply_rom_bytes, .rom_total_bytes);
  hpf_far_end far (.aclk, .aresetn, .stall, .rx_pop, .tx_ready, .rx_data, .rx_empty);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    compares++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic wrap_up();
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : wrap_up

  task automatic tmo(input int n);
    if (n >= 200)
    begin
      num_errors++;
      wrap_up();
    end
  endtask : tmo

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
    input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_awvalid && s_axi_awready)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
        s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 200);
    tmo(n);
    s_axi_bready <= 1'b0;
    chk({32'h0, s_axi_bresp}, {32'h0, er});
  endtask : wr

  // Expected word is queued before the request; the monitor pairs it
  task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    int n;
    n = 0;
    rd_q.push_back({er, d});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do
    begin
      @(posedge aclk);
      n++;
      if (s_axi_arvalid && s_axi_arready)
        s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 200);
    tmo(n);
    s_axi_rready <= 1'b0;
  endtask : rd

  // Hold and release of transmit stay with the host outside this block
  task automatic pkt(input int q, input logic [31:0] head);
    logic [31:0] d;
    tx_q.push_back({2'(q), head});
    wr(OFS_HEAD, head, STRB_FULL, RESP_OKAY);
    for (int k = 0; k < 2; k++)
    begin
      d = xs();
      tx_q.push_back({2'(q), d});
      wr(k ? OFS_TAIL : OFS_BODY, d, STRB_FULL, RESP_OKAY);
    end
  endtask : pkt

  // Results land here; an unexpected one meets an unknown note and fails
  always @(posedge aclk)
  begin
    if (s_axi_rvalid && s_axi_rready)
    begin
      m = (rd_q.size() > 0) ? rd_q.pop_front() : 'x;
      chk({s_axi_rresp, s_axi_rdata}, m);
    end
    for (int q = 0; q < 3; q++)
      if (tx_valid[q] && tx_ready[q])
      begin
        m = (tx_q.size() > 0) ? tx_q.pop_front() : 'x;
        chk({2'(q), tx_data}, m);
      end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    for (int i = 0; i < 3; i++)
      rd(OFS_HEAD + 8'(4 * i), RST_ZERO, RESP_OKAY);
    rd(OFS_ROM, RST_ZERO, RESP_OKAY);
    rd(8'h7C, RST_ZERO, RESP_SLVERR);
    wr(OFS_BODY, 32'h12345678, STRB_FULL, RESP_OKAY);
    wr(OFS_HEAD, 32'h0, 4'h3, RESP_SLVERR);
    wr(OFS_DEST_LO, 32'h1, STRB_FULL, RESP_SLVERR);
    // Tx FIFO fills while the far side stalls, then drains unevenly
    stall <= 1'b1;
    fork
      begin
        pkt(0, 32'h0000C0E1);
        pkt(1, 32'h00009410);
        pkt(2, 32'h0000E800);
      end
      begin
        repeat (40) @(posedge aclk);
        chk({33'h0, s_axi_bvalid}, 34'h0);
        chk({31'h0, tx_valid}, 34'h1);
        repeat (60)
        begin
          @(posedge aclk);
          stall <= 1'(xs());
        end
        stall <= 1'b0;
      end
    join
    repeat (10) @(posedge aclk);
    chk({31'h0, tx_valid}, 34'h0);
    chk(34'(tx_q.size()), 34'h0);
    for (int q = 0; q < 3; q++)
      for (int k = 0; k < 3; k++)
        rd(OFS_RX[q], 32'hA0000000 | (q << 16) | 32'(k > 0), RESP_OKAY);
    e = {2'h0, 11'h3FF, 5'h0, 10'h227, 6'h0};
    wr(OFS_ROM, e[31:0], STRB_FULL, RESP_OKAY);
    wr(OFS_ROM, {11'h3FF, 5'h0, AR_LIMIT, 6'h0}, STRB_FULL, RESP_SLVERR);
    wr(OFS_ROM, {ROM_LIMIT, 5'h0, 10'h1, 6'h0}, STRB_FULL, RESP_SLVERR);
    wr(OFS_ROM, 32'h0, 4'hE, RESP_SLVERR);
    chk({13'h0, rom_total_bytes, auto_reply_rom_bytes}, {13'h0, 11'h3FF, 10'h227});
    @(posedge aclk);
    bus_reset <= 1'b1;
    @(posedge aclk);
    bus_reset <= 1'b0;
    rd(OFS_ROM, e[31:0], RESP_OKAY);
    rd(OFS_RX[0], RST_ZERO, RESP_OKAY);
    wr(OFS_TAIL, 32'h5A5A5A5A, STRB_FULL, RESP_OKAY);
    // Status per selector code; the split count differs for each legal code, codes 5 and 7 read zero
    timer_waiting <= 1'b1;
    for (int i = 0; i < 7; i++)
    begin
      @(posedge aclk);
      timer_selector <= sels[i];
      {timer_tcode, timer_speed, timer_label, timer_retry_limit} <= 16'(xs());
      timer_dest_offset_low <= xs();
      @(posedge aclk);
      timer_start <= 1'b1;
      @(posedge aclk);
      timer_start <= 1'b0;
      for (int k = 0; k <= i; k++)
      begin
        @(posedge aclk);
        cycle_start <= 1'b1;
        @(posedge aclk);
        cycle_start <= 1'b0;
      end
      v = (i < 5);
      e = {2'h0, 16'(i + 1), timer_retry_limit, timer_label, timer_speed, timer_tcode};
      rd(OFS_DEST_LO, v ? timer_dest_offset_low : RST_ZERO, RESP_OKAY);
      rd(OFS_HDR_INFO, v ? e[31:0] : RST_ZERO, RESP_OKAY);
    end
    repeat (4) @(posedge aclk);
    chk(34'(rd_q.size()), 34'h0);
    wrap_up();
  end
endmodule : test_hpf_regs
`default_nettype wire
